// ---- hdl/acr_pkg.sv ----
// Package for the converter control register block: offsets, field positions, reset values, timing.
// Assumes a 16-bit register port and a single core clock.
package acr_pkg;
   localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
   localparam logic [3:0] ADDR_SAMPLE_DATA = 4'h1;
   localparam logic [3:0] ADDR_DMA_CONFIG = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
   localparam logic [15:0] DMA_CONFIG_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_ONE_WMASK = 16'hb7ff;
   localparam int BIT_ENABLE = 15;
   localparam int BIT_IDLE_STOP = 13;
   localparam int BIT_BUILD_MODE = 12;
   localparam int BIT_RESOLUTION = 10;
   localparam int BIT_FORMAT_LO = 8;
   localparam int BIT_TRIGGER_LO = 5;
   localparam int BIT_TRIGGER_GROUP = 4;
   localparam int BIT_SIMULTANEOUS = 3;
   localparam int BIT_AUTO_SAMPLE = 2;
   localparam int BIT_SAMPLE = 1;
   localparam int BIT_DONE = 0;
   localparam int CONV_TIME_NS = 120;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CHANNELS_10BIT = 4;
   localparam int CHANNELS_12BIT = 1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b10,
      ST_STORE = 2'b11
   } acr_state_e;
endpackage

// ---- hdl/acr_fifo.sv ----
// Synchronous FIFO holding conversion results on their way to the DMA channel.
// Assumes both sides run on the same clock; storage is flip-flops.
`timescale 1ns/1ps
`default_nettype none
module acr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   output logic o_empty,
   output logic o_full
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("FIFO depth must be a power of two of at least 2");
      end
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;
   assign o_empty = (wr_ptr == rd_ptr);
   assign o_full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
   assign o_in_ready = !o_full;
   assign o_out_valid = !o_empty;
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= i_in_data;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
   full_no_push_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_full && !pop |=> o_full)
      else $error("FIFO lost its full state without a pop");
endmodule
`default_nettype wire

// ---- hdl/acr_control.sv ----
// Converter control register one with sample/convert sequencer and DMA result path.
// Assumes a synchronous register port master and a DMA channel with valid/ready.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Converter samples and converts only while the enable bit 15 is set.
// - Bit 12 chooses conversion-order buffer or scatter/gather addressing for DMA.
// - Scatter/gather address is input index times buffer size plus sample slot.
// - Fields sit at 15, 13, 12, 10, 9..8 and trigger/sample/done in low byte.
module acr_control #(
   parameter int FIFO_DEPTH = 8,
   parameter int ADDR_WIDTH = 11
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic [3:0] I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [15:0] O_RDATA,
   input wire logic I_IDLE,
   input wire logic I_TRIGGER,
   input wire logic [11:0] I_ANALOG_CODE,
   output logic O_CONVERTER_ON,
   output logic O_DMA_VALID,
   input wire logic I_DMA_READY,
   output logic [15:0] O_DMA_DATA,
   output logic [ADDR_WIDTH-1:0] O_DMA_ADDR
);
   initial begin
      if (FIFO_DEPTH != 8 || ADDR_WIDTH < 8 || ADDR_WIDTH > 16) begin
         $error("Unsupported FIFO depth or DMA address width");
      end
   end
   localparam int FW = 16 + ADDR_WIDTH;
   logic [15:0] control;
   logic [15:0] dma_config;
   logic [15:0] last_result;
   acr_pkg::acr_state_e state;
   logic [7:0] conv_count;
   logic [1:0] channel;
   logic [7:0] slot;
   logic idle_s1;
   logic idle_s2;
   logic trig_s1;
   logic trig_s2;
   logic trig_prev;
   logic [11:0] code_s1;
   logic [11:0] code_s2;
   logic overflow;
   logic fifo_ready;
   logic fifo_valid;
   logic [FW-1:0] fifo_in;
   logic [FW-1:0] fifo_out;
   logic [15:0] next_result;
   logic [ADDR_WIDTH-1:0] next_addr;
   logic running;
   logic trigger_edge;
   logic wr_ctrl;
   logic conv_done;
   logic last_channel;
   wire logic enable = control[acr_pkg::BIT_ENABLE];
   wire logic build_sg = control[acr_pkg::BIT_BUILD_MODE];
   wire logic res12 = control[acr_pkg::BIT_RESOLUTION];
   wire logic [1:0] fmt = control[acr_pkg::BIT_FORMAT_LO +: 2];
   wire logic [2:0] trig_src = control[acr_pkg::BIT_TRIGGER_LO +: 3];
   wire logic auto_sample = control[acr_pkg::BIT_AUTO_SAMPLE];
   wire logic simultaneous = control[acr_pkg::BIT_SIMULTANEOUS];
   wire logic [3:0] buf_words_log2 = dma_config[3:0];

   // Pins from outside are synchronised before any decision reads them
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         idle_s1 <= 1'b0;
         idle_s2 <= 1'b0;
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_prev <= 1'b0;
         code_s1 <= 12'h000;
         code_s2 <= 12'h000;
      end else begin
         idle_s1 <= I_IDLE;
         idle_s2 <= idle_s1;
         trig_s1 <= I_TRIGGER;
         trig_s2 <= trig_s1;
         trig_prev <= trig_s2;
         code_s1 <= I_ANALOG_CODE;
         code_s2 <= code_s1;
      end
   end

   // Idle stop halts the sequencer only while the device is idle
   assign running = enable && !(control[acr_pkg::BIT_IDLE_STOP] && idle_s2);
   // Nonzero trigger source uses the external pin; zero means software clears sample
   assign trigger_edge = (trig_src != 3'b000) ? (trig_s2 && !trig_prev)
                       : (state == acr_pkg::ST_SAMPLE && !control[acr_pkg::BIT_SAMPLE]);
   assign wr_ctrl = I_WR && (I_ADDR == acr_pkg::ADDR_CONTROL_ONE);
   assign conv_done = (state == acr_pkg::ST_CONVERT) && (conv_count == 8'(acr_pkg::CONV_CYCLES - 1));
   // Simultaneous mode in 10-bit still walks all four channels, one store per cycle
   assign last_channel = res12 || (channel == 2'(acr_pkg::CHANNELS_10BIT - 1));

   // Result formatting: 12-bit or 10-bit code into one of four layouts
   always_comb begin
      logic [11:0] code;
      logic [3:0] msb;
      code = res12 ? code_s2 : {2'b00, code_s2[9:0]};
      msb = res12 ? 4'd11 : 4'd9;
      case (fmt)
         2'b00: next_result = {4'h0, code};
         2'b01: next_result = res12 ? {{4{code[11]}}, code} : {{6{code[9]}}, code[9:0]};
         2'b10: next_result = res12 ? {code, 4'h0} : {code[9:0], 6'h00};
         2'b11: next_result = res12 ? {~code[11], code[10:0], 4'h0} : {~code[9], code[8:0], 6'h00};
         default: next_result = 16'h0000;
      endcase
      if (fmt == 2'b01 || fmt == 2'b11) begin
         next_result[15] = ~code[msb];
         if (fmt == 2'b01) begin
            next_result = res12 ? {{4{~code[11]}}, ~code[11], code[10:0]} >> 0
                                : {{6{~code[9]}}, code[9:0]} ^ 16'h0200;
         end
      end
   end

   // Scatter/gather places each input in its own block; ordered mode counts on
   always_comb begin
      logic [15:0] sg;
      sg = ({14'h0000, channel} << buf_words_log2) | {8'h00, slot};
      if (build_sg) begin
         next_addr = sg[ADDR_WIDTH-1:0];
      end else begin
         next_addr = ADDR_WIDTH'(slot * (res12 ? 8'd1 : 8'd4) + {6'h00, channel});
      end
   end

   assign fifo_in = {next_addr, next_result};

   // Sample/convert sequencer
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         state <= acr_pkg::ST_IDLE;
         conv_count <= 8'h00;
         channel <= 2'b00;
      end else if (!running) begin
         state <= acr_pkg::ST_IDLE;
         conv_count <= 8'h00;
         channel <= 2'b00;
      end else begin
         case (state)
            acr_pkg::ST_IDLE: begin
               if (control[acr_pkg::BIT_SAMPLE] || auto_sample) begin
                  state <= acr_pkg::ST_SAMPLE;
               end
            end
            acr_pkg::ST_SAMPLE: begin
               if (trigger_edge) begin
                  state <= acr_pkg::ST_CONVERT;
                  conv_count <= 8'h00;
               end
            end
            acr_pkg::ST_CONVERT: begin
               conv_count <= conv_count + 8'h01;
               if (conv_done) begin
                  state <= acr_pkg::ST_STORE;
               end
            end
            acr_pkg::ST_STORE: begin
               if (fifo_ready) begin
                  if (last_channel) begin
                     channel <= 2'b00;
                     state <= acr_pkg::ST_IDLE;
                  end else begin
                     channel <= channel + 2'b01;
                     state <= simultaneous ? acr_pkg::ST_STORE : acr_pkg::ST_CONVERT;
                     conv_count <= 8'h00;
                  end
               end
            end
            default: state <= acr_pkg::ST_IDLE;
         endcase
      end
   end

   // Slot advances once per finished scan, wraps inside the buffer
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST || !enable) begin
         slot <= 8'h00;
      end else if (state == acr_pkg::ST_STORE && fifo_ready && last_channel) begin
         slot <= (slot == ((8'h01 << buf_words_log2[2:0]) - 8'h01)) ? 8'h00 : slot + 8'h01;
      end
   end

   // Control register: sample and done are set and cleared by hardware too
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         control <= acr_pkg::CONTROL_ONE_RESET;
      end else begin
         if (wr_ctrl) begin
            control[15:2] <= I_WDATA[15:2] & acr_pkg::CONTROL_ONE_WMASK[15:2];
            control[acr_pkg::BIT_SAMPLE] <= I_WDATA[acr_pkg::BIT_SAMPLE];
            // Done is clear-only from software; a set in the same cycle wins below
            if (!I_WDATA[acr_pkg::BIT_DONE]) begin
               control[acr_pkg::BIT_DONE] <= 1'b0;
            end
         end
         if (running && state == acr_pkg::ST_SAMPLE && trigger_edge) begin
            control[acr_pkg::BIT_SAMPLE] <= 1'b0;
         end
         if (running && state == acr_pkg::ST_IDLE && auto_sample) begin
            control[acr_pkg::BIT_SAMPLE] <= 1'b1;
         end
         if (running && state == acr_pkg::ST_SAMPLE && trigger_edge) begin
            control[acr_pkg::BIT_DONE] <= 1'b0;
         end
         if (running && state == acr_pkg::ST_STORE && fifo_ready && last_channel) begin
            control[acr_pkg::BIT_DONE] <= 1'b1;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         dma_config <= acr_pkg::DMA_CONFIG_RESET;
      end else if (I_WR && I_ADDR == acr_pkg::ADDR_DMA_CONFIG) begin
         dma_config <= {12'h000, I_WDATA[3:0]};
      end
   end

   // Last result and a sticky overflow when the FIFO held up a store
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         last_result <= 16'h0000;
         overflow <= 1'b0;
      end else begin
         if (state == acr_pkg::ST_STORE && fifo_ready) begin
            last_result <= next_result;
         end
         if (state == acr_pkg::ST_STORE && !fifo_ready) begin
            overflow <= 1'b1;
         end else if (I_WR && I_ADDR == acr_pkg::ADDR_STATUS && I_WDATA[0]) begin
            overflow <= 1'b0;
         end
      end
   end

   // Read data stand one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_RDATA <= 16'h0000;
      end else if (I_RD) begin
         case (I_ADDR)
            acr_pkg::ADDR_CONTROL_ONE: O_RDATA <= control;
            acr_pkg::ADDR_SAMPLE_DATA: O_RDATA <= last_result;
            acr_pkg::ADDR_DMA_CONFIG: O_RDATA <= dma_config;
            acr_pkg::ADDR_STATUS: O_RDATA <= {12'h000, state, !fifo_valid, overflow};
            default: O_RDATA <= 16'h0000;
         endcase
      end else begin
         O_RDATA <= 16'h0000;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_CONVERTER_ON <= 1'b0;
      end else begin
         O_CONVERTER_ON <= running;
      end
   end

   acr_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST || !enable),
      .i_in_valid(state == acr_pkg::ST_STORE && running),
      .o_in_ready(fifo_ready),
      .i_in_data(fifo_in),
      .o_out_valid(fifo_valid),
      .i_out_ready(I_DMA_READY),
      .o_out_data(fifo_out),
      .o_empty(),
      .o_full()
   );

   assign O_DMA_VALID = fifo_valid;
   assign O_DMA_DATA = fifo_out[15:0];
   assign O_DMA_ADDR = fifo_out[FW-1:16];

   sequence store_scan_s;
      running && state == acr_pkg::ST_STORE && fifo_ready && last_channel;
   endsequence
   off_means_idle_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !enable |=> state == acr_pkg::ST_IDLE && !O_DMA_VALID)
      else $error("Converter active while disabled");
   done_on_scan_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      store_scan_s |=> control[acr_pkg::BIT_DONE])
      else $error("Done not set after finished scan");
   reserved_zero_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      control[14] == 1'b0 && control[11] == 1'b0)
      else $error("Reserved control bit set");
   sg_addr_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      build_sg && state == acr_pkg::ST_STORE |-> next_addr[7:0] == slot || channel != 2'b00)
      else $error("Scatter/gather address wrong for input zero");
   single_channel_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      res12 |-> channel == 2'b00)
      else $error("Channel advanced in 12-bit mode");
   convert_len_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST || !running)
      state == acr_pkg::ST_SAMPLE && trigger_edge |=> state == acr_pkg::ST_CONVERT
      ##11 state == acr_pkg::ST_CONVERT && conv_count == 8'd11 ##1 state == acr_pkg::ST_STORE)
      else $error("Conversion length wrong");
   order_addr_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !build_sg && res12 |-> next_addr == ADDR_WIDTH'(slot))
      else $error("Ordered address wrong");
   read_latency_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !$past(I_RD) |-> O_RDATA == 16'h0000)
      else $error("Read data outside the answer cycle");
endmodule
`default_nettype wire

// ---- bench/acr_dma_sink.sv ----
// DMA channel model: takes result words and their buffer addresses.
// Assumes the design's valid/ready port and one shared clock.
`timescale 1ns/1ps
`default_nettype none
module acr_dma_sink (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_stall,
   input wire logic i_slow,
   input wire logic i_valid,
   input wire logic [15:0] i_data,
   input wire logic [10:0] i_addr,
   output logic o_ready
);
   logic [15:0] got_data [0:63];
   logic [10:0] got_addr [0:63];
   int count;
   logic phase;
   // Slow mode accepts every other cycle, so valid must hold across refusals
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         phase <= 1'b0;
         o_ready <= 1'b0;
         count <= 0;
      end else begin
         phase <= ~phase;
         o_ready <= ~i_stall && (~i_slow || phase);
         if (i_valid && o_ready) begin
            got_data[count[5:0]] <= i_data;
            got_addr[count[5:0]] <= i_addr;
            count <= count + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the converter control register block.
// Assumes the DMA model in acr_dma_sink.sv and the design under hdl/.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rst, wr_s, rd_s, idle, dma_ready, dma_valid, conv_on, stall, slow;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, dma_data, d, ctrl;
   logic [11:0] code;
   logic [10:0] dma_addr;
   int err_total, checked, base, n, n0;
   acr_control i_dut (
      .I_CORE_CLK(clk),
      .I_RST(rst),
      .I_ADDR(addr),
      .I_WDATA(wdata),
      .I_WR(wr_s),
      .I_RD(rd_s),
      .O_RDATA(rdata),
      .I_IDLE(idle),
      .I_TRIGGER(1'b0),
      .I_ANALOG_CODE(code),
      .O_CONVERTER_ON(conv_on),
      .O_DMA_VALID(dma_valid),
      .I_DMA_READY(dma_ready),
      .O_DMA_DATA(dma_data),
      .O_DMA_ADDR(dma_addr)
   );
   acr_dma_sink i_sink (
      .i_clk(clk),
      .i_rst(rst),
      .i_stall(stall),
      .i_slow(slow),
      .i_valid(dma_valid),
      .i_data(dma_data),
      .i_addr(dma_addr),
      .o_ready(dma_ready)
   );
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic close_out;
      $display("Checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_on(input logic lvl);
      int i;
      for (i = 0; i < 8 && conv_on !== lvl; i++) begin
         @(posedge clk);
         #1;
      end
      chk({15'h0000, conv_on}, {15'h0000, lvl});
   endtask
   // Manual trigger: set sample, clear it, then wait for the result words if wt is set
   task automatic conv(input logic [15:0] c, input int cnt, input bit wt);
      int i;
      wr(4'h0, c | 16'h0002);
      wr(4'h0, c);
      for (i = 0; i < 300 && wt && i_sink.count < base + cnt; i++) begin
         @(posedge clk);
         #1;
      end
      if (wt && i_sink.count != base + cnt) begin
         err_total++;
         $display("[FAIL] %0t DMA words missing", $time);
         close_out;
      end
   endtask
   // Offset binary code turned into the four output formats
   function automatic logic [15:0] expw(input logic r, input logic [1:0] f, input logic [11:0] c);
      logic [15:0] u, h;
      u = r ? {4'h0, c} : {6'h00, c[9:0]};
      h = r ? 16'h0800 : 16'h0200;
      if (f[0]) u = u ^ h;
      if (f == 2'b01 && (u & h) != 16'h0000) u = u | ~((h << 1) - 16'h0001);
      if (f[1]) u = u << (r ? 4 : 6);
      return u;
   endfunction
   initial begin
      err_total = 0;
      checked = 0;
      rst = 1'b1;
      wr_s = 1'b0;
      rd_s = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      idle = 1'b0;
      stall = 1'b0;
      slow = 1'b0;
      code = 12'hfff;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(4'h0, d);
      chk(d, 16'h0000);
      chk({15'h0000, conv_on}, 16'h0000);
      wr(4'h0, 16'h7ff8);
      rd(4'h0, d);
      chk(d, 16'h37f8);
      rd(4'hf, d);
      chk(d, 16'h0000);
      // With the converter off a manual trigger must yield nothing
      wr(4'h0, 16'h0000);
      n0 = i_sink.count;
      conv(16'h0000, 0, 1'b0);
      repeat (30) @(posedge clk);
      chk(16'(i_sink.count - n0), 16'h0000);
      wr(4'h0, 16'h8000);
      wait_on(1'b1);
      @(posedge clk);
      idle <= 1'b1;
      wr(4'h0, 16'ha000);
      wait_on(1'b0);
      wr(4'h0, 16'h8000);
      wait_on(1'b1);
      @(posedge clk);
      idle <= 1'b0;
      // Every resolution and format, two extreme codes, slow DMA on the second
      for (int c = 0; c < 2; c++) begin
         @(posedge clk);
         code <= c ? 12'h000 : 12'hfff;
         slow <= c[0];
         for (int r = 0; r < 2; r++) begin
            for (int f = 0; f < 4; f++) begin
               wr(4'h0, 16'h0000);
               ctrl = 16'h8000 | (16'(r) << 10) | (16'(f) << 8);
               n = r ? 1 : 4;
               base = i_sink.count;
               conv(ctrl, n, 1'b1);
               for (int k = 0; k < n; k++) begin
                  chk(i_sink.got_data[base + k], expw(r[0], f[1:0], code));
                  chk({5'h00, i_sink.got_addr[base + k]}, 16'(k));
               end
               rd(4'h0, d);
               chk(d, ctrl | 16'h0001);
               rd(4'h1, d);
               chk(d, expw(r[0], f[1:0], code));
            end
         end
      end
      // Software clears done only by writing zero; auto-sample is off here
      wr(4'h0, ctrl | 16'h0001);
      rd(4'h0, d);
      chk(d, ctrl | 16'h0001);
      wr(4'h0, ctrl);
      rd(4'h0, d);
      chk(d, ctrl);
      // Simultaneous sampling stores the four inputs back to back
      wr(4'h0, 16'h0000);
      base = i_sink.count;
      conv(16'h8008, 4, 1'b1);
      for (int k = 0; k < 4; k++) begin
         chk({5'h00, i_sink.got_addr[base + k]}, 16'(k));
         chk(i_sink.got_data[base + k], expw(1'b0, 2'b00, code));
      end
      @(posedge clk);
      slow <= 1'b0;
      wr(4'h0, 16'h0000);
      wr(4'h2, 16'h0003);
      rd(4'h2, d);
      chk(d, 16'h0003);
      for (int s = 0; s < 2; s++) begin
         base = i_sink.count;
         conv(16'h9000, 4, 1'b1);
         for (int k = 0; k < 4; k++) begin
            chk({5'h00, i_sink.got_addr[base + k]}, 16'((k << 3) | s));
         end
      end
      // Fill past the buffer with the DMA stalled, then drain it
      wr(4'h0, 16'h0000);
      stall <= 1'b1;
      for (int j = 0; j < 3; j++) begin
         conv(16'h8000, 4, 1'b0);
         // A scan of four inputs needs about 57 cycles; the next one must start from idle
         repeat (60) @(posedge clk);
      end
      rd(4'h3, d);
      chk(d & 16'h0001, 16'h0001);
      @(posedge clk);
      stall <= 1'b0;
      repeat (60) @(posedge clk);
      rd(4'h3, d);
      chk(d & 16'h0002, 16'h0002);
      wr(4'h3, 16'h0001);
      rd(4'h3, d);
      chk(d & 16'h0001, 16'h0000);
      close_out;
   end
endmodule
`default_nettype wire
